// ===== rtl/tmr01_pkg.sv
// package for the dual timer/counter and external interrupt flag block
// assumes one core clock; the core's register port and vector acks feed it
package tmr01_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h88;
    localparam logic [7:0] ADDR_MODE = 8'h89;
    localparam logic [7:0] ADDR_A_LO = 8'h8a;
    localparam logic [7:0] ADDR_B_LO = 8'h8b;
    localparam logic [7:0] ADDR_A_HI = 8'h8c;
    localparam logic [7:0] ADDR_B_HI = 8'h8d;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTRL_FLAG_B  = 7;
    localparam int CTRL_RUN_B   = 6;
    localparam int CTRL_FLAG_A  = 5;
    localparam int CTRL_RUN_A   = 4;
    localparam int CTRL_EXT_B   = 3;
    localparam int CTRL_TRIG_B  = 2;
    localparam int CTRL_EXT_A   = 1;
    localparam int CTRL_TRIG_A  = 0;
    localparam int MODE_GATE_B  = 7;
    localparam int MODE_SRC_B   = 6;
    localparam int MODE_B_LSB   = 4;
    localparam int MODE_GATE_A  = 3;
    localparam int MODE_SRC_A   = 2;
    localparam int MODE_A_LSB   = 0;

    // ------------------------------------------------------------
    // reset values and counting limits
    // ------------------------------------------------------------
    localparam logic [7:0] RST_CTRL  = 8'h00;
    localparam logic [7:0] RST_MODE  = 8'h00;
    localparam logic [7:0] RST_DATA  = 8'h00;
    localparam logic [4:0] PRESC_MAX = 5'h1f;
    localparam logic [7:0] BYTE_MAX  = 8'hff;

    typedef enum logic [1:0] {
        MODE_PRESCALE = 2'b00,
        MODE_CASCADE  = 2'b01,
        MODE_RELOAD   = 2'b10,
        MODE_SPLIT    = 2'b11
    } tmr_mode_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_type;

    typedef struct packed {
        logic count_a;
        logic count_b;
        logic ext_a;
        logic ext_b;
    } pin_in_type;

    typedef struct packed {
        logic tmr_a;
        logic tmr_b;
        logic ext_a;
        logic ext_b;
    } irq_set_type;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] mode;
        logic [7:0] a_lo;
        logic [7:0] a_hi;
        logic [7:0] b_lo;
        logic [7:0] b_hi;
        pin_in_type prev;
        logic [7:0] rdata;
    } tmr_state_type;

endpackage

// ===== rtl/tmr01_ctrl.sv
// two timer/counters with mode, run, gating and overflow flags,
// plus the two external interrupt request flags of the control register
// assumes pins already synchronous to clk and one-cycle vector ack pulses
//
// Functional notes
// [R1] timer b mode 00: high byte counts behind low-byte 5-bit prescaler; 01: 16-bit
// [R2] timer b mode 10: low byte autoreloads from high byte; 11: stopped
// [R3] timer a mode 00: high byte behind 5-bit prescaler; 01: 16-bit cascade
// [R4] timer a mode 10: low byte counts, reloads from high byte on overflow
// [R5] timer a mode 11: low byte is own 8-bit timer with timer a controls
// [R6] timer a mode 11: high byte counts clocks only, run by timer b bit
// [R7] gating set: timer a counts only while ext pin a high and run set
// [R8] source select set counts count-pin events, clear counts core clocks
// [R9] timer b overflow sets its flag; vector ack clears it
// [R10] timer b run bit turns timer b on and off
// [R11] timer a overflow sets its flag; vector ack clears it
// [R12] timer a run bit turns timer a on and off
// [R13] ext flag b set by falling edge or low level; ack clears in edge mode
// [R14] ext flag a set by falling edge or low level; ack clears in edge mode
// [R15] in level mode the outside source holds and removes the request
// [R16] trigger type b set selects falling edge, clear selects low level
// [R17] trigger type a set selects falling edge, clear selects low level
// [R18] low four control bits never affect the timers
// [R19] timer mode increments once per core clock
// [R20] counter mode counts high sample then low sample; source holds each level
// [R21] mode 00 count is high byte plus low five bits; run does not clear it
// [R22] timer a mode 11 high byte overflow sets timer b flag
`timescale 1ns/1ps

module tmr01_ctrl
    import tmr01_pkg::*;
(
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    // register port
    input  wire tmr01_pkg::reg_req_type bus_req,
    output wire logic [7:0]            rdata,
    // pins and vector acknowledges
    input  wire tmr01_pkg::pin_in_type pins,
    input  wire tmr01_pkg::irq_set_type vec_ack,
    // request flags to the interrupt logic
    output wire tmr01_pkg::irq_set_type irq_flags
);
    import tmr01_pkg::*;

    // ------------------------------------------------------------
    // counting step for modes 00 to 10, shared by both timers
    // ------------------------------------------------------------
    function automatic logic [16:0] step(input logic [1:0] md,
                                         input logic [7:0] lo,
                                         input logic [7:0] hi,
                                         input logic       inc);
        logic [16:0] r;
        logic [16:0] sum;
        r   = {1'b0, hi, lo};
        sum = {1'b0, hi, lo} + 17'h00001;
        if (inc) begin
            case (tmr_mode_type'(md))
                MODE_PRESCALE: begin
                    // upper three low bits are left as they are
                    r[4:0] = lo[4:0] + 5'h01; // R21
                    if (lo[4:0] == PRESC_MAX) begin
                        r[15:8] = hi + 8'h01;
                        r[16]   = (hi == BYTE_MAX);
                    end
                end
                MODE_CASCADE: begin
                    r = sum;
                end
                MODE_RELOAD: begin
                    r[7:0] = (lo == BYTE_MAX) ? hi : lo + 8'h01;
                    r[16]  = (lo == BYTE_MAX);
                end
                default: begin
                    r = {1'b0, hi, lo};
                end
            endcase
        end
        return r;
    endfunction

    tmr_state_type st_q;
    tmr_state_type st_d;

    logic [1:0]  mode_a;
    logic [1:0]  mode_b;
    logic        en_a;
    logic        en_b;
    logic        inc_a;
    logic        inc_b;
    logic        fall_a;
    logic        fall_b;
    logic        fall_int_a;
    logic        fall_int_b;
    logic [16:0] nx_a;
    logic [16:0] nx_b;
    logic        ovf_a;
    logic        ovf_b;
    logic        ovf_split_hi;
    logic [7:0]  rd_val;

    // ------------------------------------------------------------
    // count enables and event detection
    // ------------------------------------------------------------
    assign mode_a = st_q.mode[MODE_A_LSB +: 2];
    assign mode_b = st_q.mode[MODE_B_LSB +: 2];
    // pin samples: high one cycle, low the next
    assign fall_a     = st_q.prev.count_a & ~pins.count_a; // R20
    assign fall_b     = st_q.prev.count_b & ~pins.count_b; // R20
    assign fall_int_a = st_q.prev.ext_a & ~pins.ext_a;
    assign fall_int_b = st_q.prev.ext_b & ~pins.ext_b;
    // run bit, optionally gated by the external interrupt pin
    assign en_a = st_q.ctrl[CTRL_RUN_A] & (~st_q.mode[MODE_GATE_A] | pins.ext_a); // R7 R12
    assign en_b = st_q.ctrl[CTRL_RUN_B] & (~st_q.mode[MODE_GATE_B] | pins.ext_b); // R10
    // clock cycles or count-pin events
    assign inc_a = en_a & (st_q.mode[MODE_SRC_A] ? fall_a : 1'b1); // R8 R19
    assign inc_b = en_b & (st_q.mode[MODE_SRC_B] ? fall_b : 1'b1); // R19

    // ------------------------------------------------------------
    // next counter values
    // ------------------------------------------------------------
    assign nx_a = step(mode_a, st_q.a_lo, st_q.a_hi, inc_a); // R3 R4
    assign nx_b = step(mode_b, st_q.b_lo, st_q.b_hi, inc_b & (mode_b != MODE_SPLIT)); // R1 R2
    // split mode: high byte of timer a counts clocks under timer b run
    assign ovf_split_hi = (mode_a == MODE_SPLIT) & st_q.ctrl[CTRL_RUN_B] & (st_q.a_hi == BYTE_MAX); // R6
    assign ovf_a = (mode_a == MODE_SPLIT) ? inc_a & (st_q.a_lo == BYTE_MAX) : nx_a[16]; // R5
    // while timer a is split, its high byte owns the timer b flag
    assign ovf_b = (mode_a == MODE_SPLIT) ? ovf_split_hi : nx_b[16]; // R22

    // ------------------------------------------------------------
    // read mux, sampled state before this cycle's update
    // ------------------------------------------------------------
    always_comb begin
        case (bus_req.addr)
            ADDR_CTRL: rd_val = st_q.ctrl;
            ADDR_MODE: rd_val = st_q.mode;
            ADDR_A_LO: rd_val = st_q.a_lo;
            ADDR_B_LO: rd_val = st_q.b_lo;
            ADDR_A_HI: rd_val = st_q.a_hi;
            ADDR_B_HI: rd_val = st_q.b_hi;
            default:   rd_val = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // next state: counting, then software writes, then flags
    // ------------------------------------------------------------
    always_comb begin
        st_d       = st_q;
        st_d.prev  = pins;
        st_d.rdata = bus_req.rd ? rd_val : 8'h00;
        // counters
        if (mode_a == MODE_SPLIT) begin
            if (inc_a) begin
                st_d.a_lo = st_q.a_lo + 8'h01; // R5
            end
            if (st_q.ctrl[CTRL_RUN_B]) begin
                st_d.a_hi = st_q.a_hi + 8'h01; // R6
            end
        end else begin
            st_d.a_lo = nx_a[7:0];
            st_d.a_hi = nx_a[15:8];
        end
        st_d.b_lo = nx_b[7:0];
        st_d.b_hi = nx_b[15:8];
        // software writes win over counting
        if (bus_req.wr) begin
            case (bus_req.addr)
                ADDR_CTRL: st_d.ctrl = bus_req.wdata;
                ADDR_MODE: st_d.mode = bus_req.wdata;
                ADDR_A_LO: st_d.a_lo = bus_req.wdata;
                ADDR_B_LO: st_d.b_lo = bus_req.wdata;
                ADDR_A_HI: st_d.a_hi = bus_req.wdata;
                ADDR_B_HI: st_d.b_hi = bus_req.wdata;
                default:   st_d.mode = st_d.mode;
            endcase
        end
        // timer flags: ack clears, overflow sets and wins
        if (vec_ack.tmr_a) begin
            st_d.ctrl[CTRL_FLAG_A] = 1'b0;
        end
        if (ovf_a) begin
            st_d.ctrl[CTRL_FLAG_A] = 1'b1; // R11
        end
        if (vec_ack.tmr_b) begin
            st_d.ctrl[CTRL_FLAG_B] = 1'b0;
        end
        if (ovf_b) begin
            st_d.ctrl[CTRL_FLAG_B] = 1'b1; // R9
        end
        // external flags never touch the timers; level mode follows the pin
        if (st_q.ctrl[CTRL_TRIG_A]) begin
            if (vec_ack.ext_a) begin
                st_d.ctrl[CTRL_EXT_A] = 1'b0; // R14
            end
            if (fall_int_a) begin
                st_d.ctrl[CTRL_EXT_A] = 1'b1; // R17
            end
        end else begin
            st_d.ctrl[CTRL_EXT_A] = ~pins.ext_a; // R15 R17 R18
        end
        if (st_q.ctrl[CTRL_TRIG_B]) begin
            if (vec_ack.ext_b) begin
                st_d.ctrl[CTRL_EXT_B] = 1'b0; // R13
            end
            if (fall_int_b) begin
                st_d.ctrl[CTRL_EXT_B] = 1'b1; // R16
            end
        end else begin
            st_d.ctrl[CTRL_EXT_B] = ~pins.ext_b; // R15 R16
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_q.ctrl  <= RST_CTRL;
            st_q.mode  <= RST_MODE;
            st_q.a_lo  <= RST_DATA;
            st_q.a_hi  <= RST_DATA;
            st_q.b_lo  <= RST_DATA;
            st_q.b_hi  <= RST_DATA;
            st_q.prev  <= '0;
            st_q.rdata <= 8'h00;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign rdata           = st_q.rdata;
    assign irq_flags.tmr_a = st_q.ctrl[CTRL_FLAG_A];
    assign irq_flags.tmr_b = st_q.ctrl[CTRL_FLAG_B];
    assign irq_flags.ext_a = st_q.ctrl[CTRL_EXT_A];
    assign irq_flags.ext_b = st_q.ctrl[CTRL_EXT_B];

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // ------------------------------------------------------------
    // checks: timer a counting
    // ------------------------------------------------------------
    // a software write may always overrule a count, so writes are left out
    run_off_a: assert property (!st_q.ctrl[CTRL_RUN_A] && mode_a != MODE_SPLIT && !bus_req.wr // R12
        |=> $stable(st_q.a_lo) && $stable(st_q.a_hi)) else $error("timer a moved while off");

    tick_16_a: assert property (en_a && !st_q.mode[MODE_SRC_A] && mode_a == MODE_CASCADE // R19
        && !bus_req.wr |=> st_q.a_lo == $past(st_q.a_lo) + 8'h01) else $error("no clock count");

    tick_8_a: assert property (en_a && !st_q.mode[MODE_SRC_A] && mode_a == MODE_RELOAD // R4
        && st_q.a_lo != BYTE_MAX && !bus_req.wr |=> st_q.a_lo == $past(st_q.a_lo) + 8'h01)
        else $error("no 8-bit count");

    gate_hold_a: assert property (st_q.mode[MODE_GATE_A] && !pins.ext_a && mode_a != MODE_SPLIT // R7
        && !bus_req.wr |=> $stable(st_q.a_lo)) else $error("gated timer counted");

    reload_a: assert property (inc_a && mode_a == MODE_RELOAD && st_q.a_lo == BYTE_MAX && !bus_req.wr // R4
        |=> st_q.a_lo == $past(st_q.a_hi) && st_q.ctrl[CTRL_FLAG_A]) else $error("bad reload");

    ovf_flag_a: assert property (inc_a && mode_a == MODE_CASCADE && {st_q.a_hi, st_q.a_lo} == 16'hffff // R11
        && !bus_req.wr |=> st_q.ctrl[CTRL_FLAG_A] && st_q.a_hi == 8'h00) else $error("overflow lost");

    pin_hold_a: assert property (st_q.mode[MODE_SRC_A] && !(st_q.prev.count_a && !pins.count_a) // R20
        && mode_a == MODE_CASCADE && !bus_req.wr |=> $stable(st_q.a_lo)) else $error("stray event");

    prescale_a: assert property (inc_a && mode_a == MODE_PRESCALE && st_q.a_lo[4:0] != PRESC_MAX // R3
        && !bus_req.wr |=> $stable(st_q.a_hi)) else $error("prescaler skipped");

    split_lo_a: assert property (mode_a == MODE_SPLIT && inc_a && !bus_req.wr // R5
        |=> st_q.a_lo == $past(st_q.a_lo) + 8'h01) else $error("split low byte stuck");

    split_hi_a: assert property (mode_a == MODE_SPLIT && st_q.ctrl[CTRL_RUN_B] && !bus_req.wr // R6
        |=> st_q.a_hi == $past(st_q.a_hi) + 8'h01) else $error("split high byte stuck");

    src_pin_a: assert property (st_q.mode[MODE_SRC_A] && !fall_a |-> !inc_a) // R8
        else $error("count without pin event");

    run_start_a: assert property (bus_req.wr && bus_req.addr == ADDR_CTRL && !st_q.ctrl[CTRL_RUN_A] // R21
        && mode_a != MODE_SPLIT |=> $stable(st_q.a_hi) && $stable(st_q.a_lo)) else $error("run cleared count");

    // ------------------------------------------------------------
    // checks: timer b counting
    // ------------------------------------------------------------

    run_off_b: assert property (!st_q.ctrl[CTRL_RUN_B] && mode_a != MODE_SPLIT && !bus_req.wr // R10
        |=> $stable(st_q.b_lo) && $stable(st_q.b_hi)) else $error("timer b moved while off");

    gate_hold_b: assert property (st_q.mode[MODE_GATE_B] && !pins.ext_b && !bus_req.wr // R10
        |=> $stable(st_q.b_lo)) else $error("gated timer b counted");

    stop_b_a: assert property (mode_b == MODE_SPLIT && !bus_req.wr // R2
        |=> $stable(st_q.b_lo) && $stable(st_q.b_hi)) else $error("timer b counted in mode 11");

    tick_16_b: assert property (en_b && !st_q.mode[MODE_SRC_B] && mode_b == MODE_CASCADE // R1
        && !bus_req.wr |=> st_q.b_lo == $past(st_q.b_lo) + 8'h01) else $error("timer b no count");

    prescale_b: assert property (inc_b && mode_b == MODE_PRESCALE && !bus_req.wr // R21
        |=> st_q.b_lo[7:5] == $past(st_q.b_lo[7:5])) else $error("prescaler top bits moved");

    ovf_flag_b: assert property (inc_b && mode_b == MODE_CASCADE && mode_a != MODE_SPLIT // R9
        && {st_q.b_hi, st_q.b_lo} == 16'hffff && !bus_req.wr |=> irq_flags.tmr_b && st_q.b_hi == 8'h00)
        else $error("timer b overflow lost");

    reload_b: assert property (inc_b && mode_b == MODE_RELOAD && st_q.b_lo == BYTE_MAX && !bus_req.wr // R2
        |=> st_q.b_lo == $past(st_q.b_hi)) else $error("timer b bad reload");

    split_ovf_b: assert property (ovf_split_hi && !bus_req.wr |=> irq_flags.tmr_b && st_q.a_hi == 8'h00) // R22
        else $error("split overflow lost");

    // ------------------------------------------------------------
    // checks: request flags
    // ------------------------------------------------------------
    // set beats ack in the same cycle
    ovf_hold_a: assert property (ovf_a |=> irq_flags.tmr_a) else $error("timer a flag lost"); // R11

    tmr_ack_a: assert property (vec_ack.tmr_a && !ovf_a && !bus_req.wr |=> !irq_flags.tmr_a) // R11
        else $error("timer a flag kept");

    ovf_hold_b: assert property (ovf_b |=> irq_flags.tmr_b) else $error("timer b flag lost"); // R9

    tmr_ack_b: assert property (vec_ack.tmr_b && !ovf_b && !bus_req.wr |=> !irq_flags.tmr_b) // R9
        else $error("timer b flag kept");

    // external flags, edge and level
    edge_set_a: assert property (st_q.ctrl[CTRL_TRIG_A] && pins.ext_a ##1 st_q.ctrl[CTRL_TRIG_A] // R17
        && !pins.ext_a |=> irq_flags.ext_a) else $error("edge missed");

    ack_clr_a: assert property (st_q.ctrl[CTRL_TRIG_A] && vec_ack.ext_a && !fall_int_a // R14
        && !bus_req.wr |=> !irq_flags.ext_a) else $error("edge flag a kept");

    level_a: assert property (!st_q.ctrl[CTRL_TRIG_A] |=> irq_flags.ext_a == !$past(pins.ext_a)) // R17
        else $error("level flag a wrong");

    level_ack_a: assert property (!st_q.ctrl[CTRL_TRIG_A] && vec_ack.ext_a && !pins.ext_a // R14
        |=> irq_flags.ext_a) else $error("level flag a cleared by ack");

    edge_set_b: assert property (st_q.ctrl[CTRL_TRIG_B] && pins.ext_b ##1 st_q.ctrl[CTRL_TRIG_B] // R16
        && !pins.ext_b |=> irq_flags.ext_b) else $error("edge b missed");

    level_b: assert property (!st_q.ctrl[CTRL_TRIG_B] |=> irq_flags.ext_b == !$past(pins.ext_b)) // R16
        else $error("level flag wrong");

    ack_clr_b: assert property (st_q.ctrl[CTRL_TRIG_B] && vec_ack.ext_b && !fall_int_b // R13
        && !bus_req.wr |=> !irq_flags.ext_b) else $error("edge flag kept");

    // ------------------------------------------------------------
    // checks: register port
    // ------------------------------------------------------------

    read_lat_a: assert property (bus_req.rd && bus_req.addr == ADDR_MODE |=> rdata == $past(st_q.mode))
        else $error("read data wrong");

    read_zero_a: assert property (!bus_req.rd |=> rdata == 8'h00)
        else $error("read data without strobe");

    // ------------------------------------------------------------
    // covers
    // ------------------------------------------------------------
    // main scenarios worth seeing once
    prescale_c: cover property (inc_a && mode_a == MODE_PRESCALE && st_q.a_lo[4:0] == PRESC_MAX);
    split_c:    cover property (ovf_split_hi ##1 ovf_a);
    ext_ack_c:  cover property (fall_int_a && vec_ack.ext_a && st_q.ctrl[CTRL_TRIG_A]);
    counter_c:  cover property (st_q.mode[MODE_SRC_B] && inc_b);
    edge_b_c:   cover property (fall_int_b && st_q.ctrl[CTRL_TRIG_B]);

endmodule

// ===== testbench/pin_drv.sv
// far-side model: external count pins and external interrupt pins
// assumes bench controls change just after a rising clk edge
`timescale 1ns/1ps

module pin_drv
    import tmr01_pkg::*;
(
    // clock
    input  wire logic             clk,
    // bench controls
    input  wire logic             cnt_en,
    input  wire logic             ext_a_lvl,
    input  wire logic             ext_b_lvl,
    // pins toward the block
    output wire tmr01_pkg::pin_in_type pins
);
    // ------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------
    // count pins idle low, interrupt pins idle high (no request)
    pin_in_type pins_q = 4'b0011;

    // toggling each cycle holds every level one full cycle
    always @(posedge clk) begin
        if (cnt_en) begin
            pins_q.count_a <= ~pins_q.count_a;
            pins_q.count_b <= ~pins_q.count_b;
        end
        pins_q.ext_a <= ext_a_lvl;
        pins_q.ext_b <= ext_b_lvl;
    end

    assign pins = pins_q;
endmodule

// ===== testbench/testbench.sv
// self-checking bench for the timer/counter and external flag block
// assumes the pin model drives pins; register port driven here
`timescale 1ns/1ps

module testbench;
    import tmr01_pkg::*;
    logic        clk;
    logic        sys_rst;
    logic        cnt_en;
    logic        ext_a_lvl;
    logic        ext_b_lvl;
    reg_req_type bus_req;
    irq_set_type vec_ack;
    irq_set_type irq_flags;
    pin_in_type  pins;
    logic [7:0]  rdata;
    int          err_total;
    int          cmp_count;

    tmr01_ctrl dut_u (.clk(clk), .sys_rst(sys_rst), .bus_req(bus_req), .rdata(rdata),
                      .pins(pins), .vec_ack(vec_ack), .irq_flags(irq_flags));
    pin_drv far_u (.clk(clk), .cnt_en(cnt_en), .ext_a_lvl(ext_a_lvl), .ext_b_lvl(ext_b_lvl),
                   .pins(pins));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic end_sim;
        if (err_total == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus_req.wr <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus_req.rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask

    task automatic flags_chk(input logic [3:0] exp);
        #1 chk({4'h0, irq_flags}, {4'h0, exp});
    endtask

    task automatic ack(input logic [3:0] v);
        @(posedge clk);
        vec_ack <= v;
        @(posedge clk);
        vec_ack <= '0;
    endtask

    task automatic set_ext(input bit b, input logic v);
        @(posedge clk);
        if (b)
            ext_b_lvl <= v;
        else
            ext_a_lvl <= v;
    endtask

    // one count of the timer in the given mode: {wrap, hi, lo}
    function automatic logic [16:0] tstep(input logic [1:0] m, input logic [15:0] v);
        logic [13:0] s;
        s = {1'b0, v[15:8], v[4:0]} + 14'h0001;
        case (m)
            2'b00:   return {s[13], s[12:5], v[7:5], s[4:0]};
            2'b01:   return {1'b0, v} + 17'h00001;
            2'b10:   return (v[7:0] == 8'hff) ? {1'b1, v[15:8], v[15:8]} : {1'b0, v + 16'h0001};
            default: return {1'b0, v};
        endcase
    endfunction

    // six counts with an ack on the fourth edge of running
    task automatic mode_case(input bit b, input logic [1:0] m, input logic [15:0] init);
        logic [15:0] v;
        logic [16:0] r;
        logic [3:0]  fm;
        logic        early;
        logic        late;
        v = init;
        early = 1'b0;
        late = 1'b0;
        for (int i = 1; i <= 6; i++) begin
            r = tstep(m, v);
            v = r[15:0];
            early |= r[16] && i <= 2;
            late |= r[16] && i == 4;
        end
        fm = b ? 4'b0100 : 4'b1000;
        wr_reg(ADDR_MODE, b ? {2'b00, m, 4'h0} : {6'h00, m});
        wr_reg(b ? ADDR_B_LO : ADDR_A_LO, init[7:0]);
        wr_reg(b ? ADDR_B_HI : ADDR_A_HI, init[15:8]);
        wr_reg(ADDR_CTRL, b ? 8'h40 : 8'h10);
        repeat (2) @(posedge clk);
        flags_chk(early ? fm : 4'h0);
        ack(fm);
        flags_chk(late ? fm : 4'h0);
        wr_reg(ADDR_CTRL, 8'h00);
        rd_chk(b ? ADDR_B_LO : ADDR_A_LO, v[7:0]);
        rd_chk(b ? ADDR_B_HI : ADDR_A_HI, v[15:8]);
    endtask

    // ------------------------------------------------------------
    // watchdog: a hang counts as a mismatch
    // ------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        end_sim();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        err_total = 0;
        cmp_count = 0;
        sys_rst = 1'b1;
        bus_req = '0;
        vec_ack = '0;
        cnt_en = 1'b0;
        ext_a_lvl = 1'b1;
        ext_b_lvl = 1'b1;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        // reset values, 0x8e is unmapped
        for (int a = 8'h88; a <= 8'h8e; a++)
            rd_chk(a[7:0], 8'h00);
        // every mode of both timers; split mode of timer a done below
        for (int b = 0; b < 2; b++)
            for (int m = 0; m < 4; m++)
                if (b == 1 || m != 3)
                    mode_case(b[0], m[1:0], (m == 2) ? 16'h10ff : 16'hffff);
        // split: low byte on count pin (idle), high byte on clocks, run b
        wr_reg(ADDR_MODE, 8'h07);
        wr_reg(ADDR_A_LO, 8'hfe);
        wr_reg(ADDR_A_HI, 8'hff);
        wr_reg(ADDR_CTRL, 8'h50);
        repeat (2) @(posedge clk);
        flags_chk(4'b0100);
        wr_reg(ADDR_CTRL, 8'h00);
        rd_chk(ADDR_A_LO, 8'hfe);
        rd_chk(ADDR_A_HI, 8'h03);
        // counter mode: ten toggles give five falling edges
        wr_reg(ADDR_MODE, 8'h05);
        wr_reg(ADDR_A_LO, 8'h00);
        wr_reg(ADDR_A_HI, 8'h00);
        wr_reg(ADDR_CTRL, 8'h10);
        @(posedge clk);
        cnt_en <= 1'b1;
        repeat (10) @(posedge clk);
        cnt_en <= 1'b0;
        repeat (2) @(posedge clk);
        wr_reg(ADDR_CTRL, 8'h00);
        rd_chk(ADDR_A_LO, 8'h05);
        // gating: pin low blocks counting, pin high lets six counts through
        wr_reg(ADDR_MODE, 8'h09);
        wr_reg(ADDR_A_LO, 8'h00);
        set_ext(1'b0, 1'b0);
        repeat (3) @(posedge clk);
        wr_reg(ADDR_CTRL, 8'h10);
        repeat (4) @(posedge clk);
        wr_reg(ADDR_CTRL, 8'h00);
        rd_chk(ADDR_A_LO, 8'h00);
        set_ext(1'b0, 1'b1);
        repeat (3) @(posedge clk);
        wr_reg(ADDR_CTRL, 8'h10);
        repeat (4) @(posedge clk);
        wr_reg(ADDR_CTRL, 8'h00);
        rd_chk(ADDR_A_LO, 8'h06);
        // external flags: level mode ignores ack, edge mode holds until ack
        for (int b = 0; b < 2; b++) begin
            set_ext(b[0], 1'b0);
            repeat (3) @(posedge clk);
            flags_chk(b ? 4'b0001 : 4'b0010);
            ack(b ? 4'b0001 : 4'b0010);
            flags_chk(b ? 4'b0001 : 4'b0010);
            set_ext(b[0], 1'b1);
            repeat (3) @(posedge clk);
            flags_chk(4'h0);
            wr_reg(ADDR_CTRL, b ? 8'h04 : 8'h01);
            set_ext(b[0], 1'b0);
            set_ext(b[0], 1'b1);
            repeat (3) @(posedge clk);
            flags_chk(b ? 4'b0001 : 4'b0010);
            rd_chk(ADDR_CTRL, b ? 8'h0c : 8'h03);
            ack(b ? 4'b0001 : 4'b0010);
            flags_chk(4'h0);
            wr_reg(ADDR_CTRL, 8'h00);
        end
        end_sim();
    end
endmodule
